/* hw/bmr_master.v */
// read side of the synchronous external bus master
`timescale 1ns/10ps
`default_nettype none
`include "bmr_regs.vh"
module bmr_master #(
   parameter FIFO_DEPTH = `BMR_FIFO_DEPTH,
   parameter FIFO_AW    = `BMR_FIFO_AW
) (
   input  wire        SYS_CLK,
   input  wire        RST,
   // request from the memory unit
   input  wire        REQ_VALID,
   output wire        REQ_READY,
   input  wire [31:0] REQ_ADDR,
   input  wire [1:0]  REQ_SIZE,
   input  wire        REQ_NONCACHABLE,
   input  wire        PAGE_USER_BIT_HI,
   input  wire        PAGE_USER_BIT_LO,
   input  wire [1:0]  REQ_TRANSFER_TYPE,
   input  wire [2:0]  REQ_TRANSFER_MODIFIER,
   // bus outputs, active high in this model
   output reg  [31:0] BUS_ADDR,
   output reg  [1:0]  SIZE_LINES,
   output reg  [1:0]  USER_ATTRIBUTE_OUT,
   output reg  [1:0]  TRANSFER_TYPE_CODE,
   output reg  [2:0]  TRANSFER_MODIFIER_CODE,
   output reg         READ_WRITE,
   output reg         CACHE_INHIBIT_OUT,
   output reg         TRANSFER_START_STROBE,
   output reg         TRANSFER_IN_PROGRESS,
   // bus inputs
   input  wire        TRANSFER_ACKNOWLEDGE,
   input  wire        BURST_INHIBIT_IN,
   input  wire        CACHE_INHIBIT_IN,
   input  wire [31:0] BUS_DATA,
   // returned words to the memory unit
   output wire        RSP_VALID,
   input  wire        RSP_READY,
   output wire [31:0] RSP_DATA,
   output wire        RSP_CACHE_INHIBIT,
   output wire        RSP_LAST
);
   localparam ST_IDLE  = 2'h0;
   localparam ST_START = 2'h1;
   localparam ST_WAIT  = 2'h2;
   // credit arithmetic needs room for a full fifo plus one more line
   localparam CREDIT_W = FIFO_AW + 2;

   reg  [1:0]          state_r;
   reg  [1:0]          state_nxt;
   reg                 is_line_r;
   reg                 is_line_nxt;
   reg                 inhibited_r;
   reg                 inhibited_nxt;
   reg  [2:0]          beat_r;
   reg  [2:0]          beat_nxt;
   reg                 ci_r;
   reg                 ci_nxt;
   reg  [CREDIT_W-1:0] credit_r;
   reg  [CREDIT_W-1:0] credit_nxt;
   wire                in_idle;
   wire                in_wait;
   wire                ack;
   wire                take_req;
   wire                first_beat;
   wire                last_beat;
   wire                fifo_ready;
   wire                fifo_space;
   wire                cont_line;
   wire                rsp_take;
   wire [CREDIT_W-1:0] req_words;
   wire [CREDIT_W-1:0] credit_sum;
   wire                word_ci;
   wire                word_last;
   wire [33:0]         fifo_in;
   wire [33:0]         fifo_out;

   // next long word within the 16-byte block, low bits untouched
   function [31:0] next_long;
      input [31:0] a;
      begin
         next_long = {a[31:4], a[3:2] + 2'h1, a[1:0]};
      end
   endfunction

   // words a request will push into the fifo: four for a line, else one
   function [CREDIT_W-1:0] words_for;
      input [1:0] siz;
      begin
         if (siz == `BMR_SIZ_LINE) begin
            words_for = {{(CREDIT_W-3){1'b0}}, `BMR_LINE_BEATS};
         end else begin
            words_for = {{(CREDIT_W-1){1'b0}}, 1'b1};
         end
      end
   endfunction

   // true when the current beat is the last word of the transfer
   function beat_is_last;
      input       line;
      input [2:0] beat;
      begin
         beat_is_last = !line || (beat == `BMR_LINE_BEATS - 3'h1);
      end
   endfunction

   // state decode
   assign in_idle = (state_r == ST_IDLE);
   assign in_wait = (state_r == ST_WAIT);

   // acknowledge only counts once the opening clock is over
   assign ack        = in_wait && TRANSFER_ACKNOWLEDGE;
   assign first_beat = (beat_r == 3'h0);
   assign last_beat  = beat_is_last(is_line_r, beat_r);
   // inhibit honoured on the first line word only; later levels are dropped
   assign cont_line  = ack && is_line_r && !last_beat &&
                       (inhibited_r || (first_beat && BURST_INHIBIT_IN));

   // credits reserve fifo room for every word of a request before it starts,
   // so a stalled consumer can never make the fifo drop an acknowledged word
   assign req_words  = words_for(REQ_SIZE);
   assign credit_sum = credit_r + req_words;
   assign fifo_space = fifo_ready && (credit_sum <= FIFO_DEPTH);
   assign REQ_READY  = (in_idle || (ack && last_beat)) && fifo_space;
   assign take_req   = REQ_VALID && REQ_READY;
   assign rsp_take   = RSP_VALID && RSP_READY;

   // cycle sequencer: idle, opening clock, then waiting for acknowledge
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (take_req) begin
               state_nxt = ST_START;
            end
         end
         ST_START: begin
            state_nxt = ST_WAIT;
         end
         ST_WAIT: begin
            if (ack && last_beat) begin
               state_nxt = take_req ? ST_START : ST_IDLE;
            end else if (cont_line) begin
               state_nxt = ST_START;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // beat bookkeeping: count, line kind, inhibit and latched cache inhibit
   always @* begin
      is_line_nxt   = is_line_r;
      inhibited_nxt = inhibited_r;
      beat_nxt      = beat_r;
      ci_nxt        = ci_r;
      if (take_req) begin
         is_line_nxt   = (REQ_SIZE == `BMR_SIZ_LINE);
         inhibited_nxt = 1'b0;
         beat_nxt      = 3'h0;
         ci_nxt        = 1'b0;
      end else if (ack && !last_beat) begin
         beat_nxt = beat_r + 3'h1;
         if (cont_line) begin
            inhibited_nxt = 1'b1;
         end
         if (first_beat) begin
            ci_nxt = CACHE_INHIBIT_IN;
         end
      end
   end

   // credit count: reserve on acceptance, release as each word leaves
   always @* begin
      credit_nxt = credit_r;
      if (take_req && !rsp_take) begin
         credit_nxt = credit_sum;
      end else if (take_req && rsp_take) begin
         credit_nxt = credit_sum - {{(CREDIT_W-1){1'b0}}, 1'b1};
      end else if (rsp_take) begin
         credit_nxt = credit_r - {{(CREDIT_W-1){1'b0}}, 1'b1};
      end
   end

   // sequencer and bookkeeping registers, all on the rising edge
   always @(posedge SYS_CLK) begin
      if (RST) begin
         state_r     <= ST_IDLE;
         is_line_r   <= 1'b0;
         inhibited_r <= 1'b0;
         beat_r      <= 3'h0;
         ci_r        <= 1'b0;
         credit_r    <= {CREDIT_W{1'b0}};
      end else begin
         state_r     <= state_nxt;
         is_line_r   <= is_line_nxt;
         inhibited_r <= inhibited_nxt;
         beat_r      <= beat_nxt;
         ci_r        <= ci_nxt;
         credit_r    <= credit_nxt;
      end
   end

   // address: loaded for the opening clock, stepped only on inhibited lines
   always @(posedge SYS_CLK) begin
      if (RST) begin
         BUS_ADDR <= 32'h00000000;
      end else if (take_req) begin
         BUS_ADDR <= REQ_ADDR;
      end else if (cont_line) begin
         BUS_ADDR <= next_long(BUS_ADDR);
      end
   end

   // size: line encoding first, follow-on reads of an inhibited line are long
   always @(posedge SYS_CLK) begin
      if (RST) begin
         SIZE_LINES <= `BMR_SIZ_LONG;
      end else if (take_req) begin
         SIZE_LINES <= REQ_SIZE;
      end else if (cont_line) begin
         SIZE_LINES <= `BMR_SIZ_LONG;
      end
   end

   // user, type and modifier codes held until the next request is taken
   always @(posedge SYS_CLK) begin
      if (RST) begin
         USER_ATTRIBUTE_OUT     <= 2'h0;
         TRANSFER_TYPE_CODE     <= 2'h0;
         TRANSFER_MODIFIER_CODE <= 3'h0;
      end else if (take_req) begin
         USER_ATTRIBUTE_OUT     <= {PAGE_USER_BIT_HI, PAGE_USER_BIT_LO};
         TRANSFER_TYPE_CODE     <= REQ_TRANSFER_TYPE;
         TRANSFER_MODIFIER_CODE <= REQ_TRANSFER_MODIFIER;
      end
   end

   // direction is always read here; cache inhibit out follows the page
   always @(posedge SYS_CLK) begin
      if (RST) begin
         READ_WRITE        <= 1'b1;
         CACHE_INHIBIT_OUT <= 1'b0;
      end else if (take_req) begin
         READ_WRITE        <= 1'b1;
         CACHE_INHIBIT_OUT <= REQ_NONCACHABLE;
      end
   end

   // start strobe lasts one clock for every cycle, follow-ons included
   always @(posedge SYS_CLK) begin
      if (RST) begin
         TRANSFER_START_STROBE <= 1'b0;
      end else begin
         TRANSFER_START_STROBE <= take_req || cont_line;
      end
   end

   // in-progress spans back-to-back cycles and a whole inhibited line
   always @(posedge SYS_CLK) begin
      if (RST) begin
         TRANSFER_IN_PROGRESS <= 1'b0;
      end else begin
         if (take_req) begin
            TRANSFER_IN_PROGRESS <= 1'b1;
         end else if (ack && last_beat) begin
            TRANSFER_IN_PROGRESS <= 1'b0;
         end
      end
   end

   // returned word with its cache-inhibit level; single reads ignore the pin
   assign word_last = is_line_r && last_beat;
   assign word_ci   = is_line_r && (first_beat ? CACHE_INHIBIT_IN : ci_r);
   assign fifo_in   = {word_last, word_ci, BUS_DATA};

   // never full when acknowledged, thanks to the credits above
   bmr_fifo #(
      .WIDTH (34),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .clk       (SYS_CLK),
      .rst       (RST),
      .in_valid  (ack),
      .in_ready  (fifo_ready),
      .in_data   (fifo_in),
      .out_valid (RSP_VALID),
      .out_ready (RSP_READY),
      .out_data  (fifo_out)
   );

   assign RSP_DATA          = fifo_out[31:0];
   assign RSP_CACHE_INHIBIT = fifo_out[32];
   assign RSP_LAST          = fifo_out[33];
endmodule
`default_nettype wire

/* hw/bmr_regs.vh */
// constants for the bus master read engine
`ifndef BMR_REGS_VH
`define BMR_REGS_VH
`define BMR_SIZ_LONG     2'h0
`define BMR_SIZ_BYTE     2'h1
`define BMR_SIZ_WORD     2'h2
`define BMR_SIZ_LINE     2'h3
`define BMR_LINE_BEATS   3'h4
`define BMR_FIFO_DEPTH   16
`define BMR_FIFO_AW      4
`define BMR_CLK_PERIOD_NS 4
`endif

/* hw/bmr_fifo.v */
// small synchronous fifo holding returned read words
`timescale 1ns/10ps
`default_nettype none
module bmr_fifo #(
   parameter WIDTH = 34,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clk,
   input  wire             rst,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output reg  [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wr_ptr_r;
   reg [AW:0]      rd_ptr_r;
   reg             out_valid_r;
   wire [AW:0]     count;
   wire            do_wr;
   wire            do_rd;
   wire            empty;

   // occupancy counts the array plus nothing of the output register
   assign count     = wr_ptr_r - rd_ptr_r;
   assign empty     = (count == {(AW+1){1'b0}});
   // full once every array slot holds a word
   assign in_ready  = (count < DEPTH);
   assign out_valid = out_valid_r;
   assign do_wr     = in_valid && in_ready;
   // refill the output register when it is empty or being taken
   assign do_rd     = !empty && (!out_valid_r || out_ready);

   // write side
   always @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr_r[AW-1:0]] <= in_data;
      end
   end

   // pointers and registered read data
   always @(posedge clk) begin
      if (rst) begin
         wr_ptr_r    <= {(AW+1){1'b0}};
         rd_ptr_r    <= {(AW+1){1'b0}};
         out_valid_r <= 1'b0;
         out_data    <= {WIDTH{1'b0}};
      end else begin
         if (do_wr) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (do_rd) begin
            out_data    <= mem[rd_ptr_r[AW-1:0]];
            rd_ptr_r    <= rd_ptr_r + 1'b1;
            out_valid_r <= 1'b1;
         end else if (out_ready) begin
            out_valid_r <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

/* verification/bmr_master_assertions.sv */
// concurrent checks on the read bus handshake of the master
`timescale 1ns/10ps
`default_nettype none
`include "bmr_regs.vh"
module bmr_master_assertions #(
   parameter FIFO_DEPTH = `BMR_FIFO_DEPTH,
   parameter FIFO_AW    = `BMR_FIFO_AW
) (
   input wire        SYS_CLK,
   input wire        RST,
   input wire        REQ_VALID,
   input wire        REQ_READY,
   input wire [31:0] BUS_ADDR,
   input wire [1:0]  SIZE_LINES,
   input wire        READ_WRITE,
   input wire        TRANSFER_START_STROBE,
   input wire        TRANSFER_IN_PROGRESS,
   input wire        TRANSFER_ACKNOWLEDGE,
   input wire        BURST_INHIBIT_IN,
   input wire        RSP_VALID
);
   // a single clock domain, so clock and reset are given once
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   strobe_one_clk_a: assert property (TRANSFER_START_STROBE |=> !TRANSFER_START_STROBE)
      else $error("start strobe held past one clock");
   req_opens_a: assert property (REQ_VALID && REQ_READY |=> TRANSFER_START_STROBE && TRANSFER_IN_PROGRESS && READ_WRITE)
      else $error("accepted request did not open a read cycle");
   opening_busy_a: assert property (TRANSFER_START_STROBE |-> !REQ_READY)
      else $error("request accepted in the opening clock");
   addr_hold_a: assert property (!TRANSFER_START_STROBE |-> $stable(BUS_ADDR) && $stable(SIZE_LINES))
      else $error("address or size moved outside an opening clock");
   tip_drop_a: assert property ($fell(TRANSFER_IN_PROGRESS) |-> $past(TRANSFER_ACKNOWLEDGE))
      else $error("in-progress dropped without a final acknowledge");
   ack_capture_a: assert property (TRANSFER_ACKNOWLEDGE && TRANSFER_IN_PROGRESS && !TRANSFER_START_STROBE |-> ##2 RSP_VALID)
      else $error("acknowledged word not delivered two clocks later");
   follow_addr_a: assert property (TRANSFER_START_STROBE && $past(TRANSFER_ACKNOWLEDGE && BURST_INHIBIT_IN) && $past(SIZE_LINES) == `BMR_SIZ_LINE |-> BUS_ADDR[3:2] == $past(BUS_ADDR[3:2]) + 2'h1 && BUS_ADDR[1:0] == $past(BUS_ADDR[1:0]) && SIZE_LINES == `BMR_SIZ_LONG)
      else $error("follow-on address of inhibited line is wrong");
   tip_cover_a: assert property (TRANSFER_START_STROBE |-> TRANSFER_IN_PROGRESS ##1 TRANSFER_IN_PROGRESS)
      else $error("in-progress not high through the opening clock");
endmodule
`default_nettype wire

/* verification/bmr_slave.sv */
// memory slave model answering the read bus
`timescale 1ns/10ps
`default_nettype none
module bmr_slave (
   input wire        SYS_CLK,
   input wire        RST,
   input wire        TRANSFER_START_STROBE,
   input wire [31:0] BUS_ADDR,
   input wire [1:0]  SIZE_LINES,
   input wire [3:0]  WAIT_CYCLES,
   input wire        NO_BURST,
   input wire        SET_CI,
   output reg        TRANSFER_ACKNOWLEDGE = 1'b0,
   output reg        BURST_INHIBIT_IN = 1'b0,
   output reg        CACHE_INHIBIT_IN = 1'b0,
   output reg [31:0] BUS_DATA = 32'h0
);
   integer    beats = 0;
   integer    cnt = 0;
   reg [31:0] adr = 32'h0;
   reg        first = 1'b0;
   // idle data toggles so stale words never look valid; inhibits repeat on purpose
   always @(posedge SYS_CLK) begin
      TRANSFER_ACKNOWLEDGE <= 1'b0;
      BURST_INHIBIT_IN <= 1'b0;
      CACHE_INHIBIT_IN <= 1'b0;
      BUS_DATA <= ~BUS_DATA;
      if (RST) beats = 0;
      else if (TRANSFER_START_STROBE) begin
         beats = (SIZE_LINES == 2'h3 && !NO_BURST) ? 4 : 1;
         cnt = WAIT_CYCLES;
         adr = BUS_ADDR;
         first = 1'b1;
      end
      if (beats != 0 && cnt != 0) cnt = cnt - 1;
      else if (beats != 0) begin
         TRANSFER_ACKNOWLEDGE <= 1'b1;
         // later burst beats flip both inhibits, which the master must ignore
         BURST_INHIBIT_IN <= first ? NO_BURST : 1'b1;
         CACHE_INHIBIT_IN <= first ? SET_CI : !SET_CI;
         first = 1'b0;
         BUS_DATA <= {adr[31:2], 2'h0} ^ 32'hA5A50000;
         adr[3:2] = adr[3:2] + 2'h1;
         beats = beats - 1;
         cnt = WAIT_CYCLES;
      end
   end
endmodule
`default_nettype wire

/* verification/bmr_master_tb.sv */
// self-checking bench for the bus master read engine
`timescale 1ns/10ps
`default_nettype none
`include "bmr_regs.vh"
module bmr_master_tb;
   reg         clk = 1'b0;
   reg         rst = 1'b1;
   reg         valid = 1'b0;
   reg  [31:0] addr = 32'h0;
   reg  [1:0]  size = 2'h0;
   reg         nc = 1'b0;
   reg         rdy = 1'b1;
   reg  [3:0]  wt = 4'h0;
   reg         nob = 1'b0;
   reg         ci = 1'b0;
   wire        ready, rw, cio, ts, transfer_in_progress, ack, burst_inhibit_in, cache_inhibit_in, rv, rci, rlast;
   wire [31:0] badr, bdat, rdat;
   wire [1:0]  siz, upa, tt;
   wire [2:0]  tm;
   integer     num_errors = 0;
   integer     total_checks = 0;
   integer     cycles = 0;
   reg  [33:0] rq[$];
   bmr_master dut (.SYS_CLK(clk), .RST(rst), .REQ_VALID(valid), .REQ_READY(ready),
      .REQ_ADDR(addr), .REQ_SIZE(size), .REQ_NONCACHABLE(nc), .PAGE_USER_BIT_HI(addr[5]),
      .PAGE_USER_BIT_LO(addr[4]), .REQ_TRANSFER_TYPE(addr[7:6]), .REQ_TRANSFER_MODIFIER(addr[10:8]),
      .BUS_ADDR(badr), .SIZE_LINES(siz), .USER_ATTRIBUTE_OUT(upa), .TRANSFER_TYPE_CODE(tt),
      .TRANSFER_MODIFIER_CODE(tm), .READ_WRITE(rw), .CACHE_INHIBIT_OUT(cio),
      .TRANSFER_START_STROBE(ts), .TRANSFER_IN_PROGRESS(transfer_in_progress), .TRANSFER_ACKNOWLEDGE(ack),
      .BURST_INHIBIT_IN(burst_inhibit_in), .CACHE_INHIBIT_IN(cache_inhibit_in), .BUS_DATA(bdat), .RSP_VALID(rv),
      .RSP_READY(rdy), .RSP_DATA(rdat), .RSP_CACHE_INHIBIT(rci), .RSP_LAST(rlast));
   bmr_slave slv (.SYS_CLK(clk), .RST(rst), .TRANSFER_START_STROBE(ts), .BUS_ADDR(badr),
      .SIZE_LINES(siz), .WAIT_CYCLES(wt), .NO_BURST(nob), .SET_CI(ci),
      .TRANSFER_ACKNOWLEDGE(ack), .BURST_INHIBIT_IN(burst_inhibit_in), .CACHE_INHIBIT_IN(cache_inhibit_in), .BUS_DATA(bdat));
   initial forever #2 clk = ~clk;
   task close_out;
      begin
         $display("checks %0d errors %0d", total_checks, num_errors);
         if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   // response monitor and hang guard
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (rv === 1'b1 && rdy) rq.push_back({rlast, rci, rdat});
      if (cycles == 20000) begin
         num_errors = num_errors + 1;
         close_out;
      end
   end
   task chk(input [47:0] exp, input [47:0] got);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD %0t exp %h got %h", $time, exp, got);
         end
      end
   endtask
   // one read: opening-clock attributes, cycle length, returned words
   task run(input [31:0] a, input [1:0] s, input n_c, input integer clocks);
      integer   n;
      integer   k;
      reg [1:0] lw;
      reg [33:0] w;
      begin
         @(negedge clk);
         addr = a;
         size = s;
         nc = n_c;
         valid = 1'b1;
         while (ready !== 1'b1) @(negedge clk);
         @(negedge clk);
         valid = 1'b0;
         chk({a, s, 1'b1, n_c, a[5:4], a[7:6], a[10:8]}, {badr, siz, rw, cio, upa, tt, tm});
         n = 0;
         while (transfer_in_progress === 1'b1 && n < 60) begin
            n = n + 1;
            @(negedge clk);
         end
         chk(clocks, n);
         repeat (4) @(negedge clk);
         chk(s == `BMR_SIZ_LINE ? 4 : 1, rq.size());
         lw = a[3:2];
         for (k = 0; k < (s == `BMR_SIZ_LINE ? 4 : 1); k = k + 1) begin
            w = rq.pop_front();
            chk({s == `BMR_SIZ_LINE && k == 3, s == `BMR_SIZ_LINE && ci, {a[31:4], lw, 2'h0} ^ 32'hA5A50000}, w);
            lw = lw + 2'h1;
         end
      end
   endtask
   // cache and burst inhibit raised on single reads must be ignored
   task t_singles;
      begin
         ci = 1'b1;
         nob = 1'b1;
         run(32'h1357_9BD1, `BMR_SIZ_BYTE, 1'b1, 2);
         run(32'h2468_ACE2, `BMR_SIZ_WORD, 1'b0, 2);
         wt = 4'h3;
         run(32'h0F0F_0734, `BMR_SIZ_LONG, 1'b1, 5);
      end
   endtask
   // wrapping burst, zero wait then one wait per beat
   task t_burst;
      begin
         nob = 1'b0;
         wt = 4'h0;
         run(32'h2000_05CE, `BMR_SIZ_LINE, 1'b0, 5);
         ci = 1'b0;
         wt = 4'h1;
         run(32'h4000_0309, `BMR_SIZ_LINE, 1'b1, 9);
      end
   endtask
   // non-burst slave forces three follow-on long reads
   task t_inhib;
      begin
         nob = 1'b1;
         ci = 1'b1;
         wt = 4'h0;
         run(32'h3000_0247, `BMR_SIZ_LINE, 1'b0, 8);
      end
   endtask
   // stalled consumer: fifo fills until requests are refused, then drains
   task t_fill;
      integer acc;
      begin
         acc = 0;
         rdy = 1'b0;
         @(negedge clk);
         addr = 32'h5000_0010;
         size = `BMR_SIZ_LONG;
         valid = 1'b1;
         #1;
         repeat (80) begin
            if (ready === 1'b1) acc = acc + 1;
            @(negedge clk);
         end
         valid = 1'b0;
         rdy = 1'b1;
         repeat (30) @(negedge clk);
         chk(acc, rq.size());
         chk(acc > 0 && acc <= 16, 1);
         rq.delete();
      end
   endtask
   initial begin
      repeat (12) @(negedge clk);
      rst = 1'b0;
      t_singles;
      t_burst;
      t_inhib;
      t_fill;
      close_out;
   end
endmodule
bind bmr_master bmr_master_assertions #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) chk_i (
   .SYS_CLK, .RST, .REQ_VALID, .REQ_READY, .BUS_ADDR, .SIZE_LINES, .READ_WRITE,
   .TRANSFER_START_STROBE, .TRANSFER_IN_PROGRESS, .TRANSFER_ACKNOWLEDGE, .BURST_INHIBIT_IN,
   .RSP_VALID);
`default_nettype wire
